// ---- rtl/lrts_regs.svh ----
// Purpose: offsets, fields, reset values and timing counts of the limit relay block
// Assumes: 32-bit register words on AHB-Lite, byte addresses below
// Notes:   definitions only
`ifndef LRTS_REGS_SVH
`define LRTS_REGS_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define LRTS_CLK_HZ          32'h017d7840
`define LRTS_SEC_S           32'h00000001
`define LRTS_DELAY_STEP_S    32'h00000005
`define LRTS_DELAY_MAX_S     32'h000000fa
`define LRTS_DELAY_STEPS_MAX (`LRTS_DELAY_MAX_S / `LRTS_DELAY_STEP_S)
`define LRTS_TO_STEP_S       32'h00000005
`define LRTS_TO_MIN_S        32'h00000005
`define LRTS_TO_MAX_S        32'h0000003c
`define LRTS_TO_STEPS_MIN    (`LRTS_TO_MIN_S / `LRTS_TO_STEP_S)
`define LRTS_TO_STEPS_MAX    (`LRTS_TO_MAX_S / `LRTS_TO_STEP_S)
`define LRTS_TO_DEF_STEPS    4'h2

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define LRTS_OFF_CTRL        8'h00
`define LRTS_OFF_STATUS      8'h04
`define LRTS_OFF_DISP_TAG    8'h08
`define LRTS_OFF_DISP_HEX    8'h0c
`define LRTS_OFF_PV          8'h10
`define LRTS_OFF_SV          8'h14
`define LRTS_OFF_TV          8'h18
`define LRTS_OFF_QV          8'h1c
`define LRTS_CH_REGION       3'h1

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define LRTS_CTRL_FRESET     0
`define LRTS_CTRL_TO_LSB     4
`define LRTS_CFG_DIR_MAX     3
`define LRTS_CFG_ACTIVE      4
`define LRTS_CFG_INHIBIT     5
`define LRTS_CFG_FAULT       6
`define LRTS_CFG_DELAY_LSB   8
`define LRTS_CFG_DEF         32'h00000000
`define LRTS_LIM_DEF         32'h000a0050
`define LRTS_CMD_VALUES      8'h03
`define LRTS_RESP_TAG        16'h5243

`endif

// ---- rtl/lrts_pkg.sv ----
// Purpose: types shared by the limit relay block
// Assumes: nothing
// Notes:   numbers live in lrts_regs.svh
package lrts_pkg;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LOOP_LOCATE = 2'b00,
    LOOP_POLL   = 2'b01,
    LOOP_BURST  = 2'b10,
    LOOP_MIXED  = 2'b11
  } lrts_loop_type;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WDATA = 2'b01,
    BUS_RWAIT = 2'b10,
    BUS_RDATA = 2'b11
  } lrts_bus_type;

  typedef enum logic [2:0] {
    SEL_OFF = 3'b000,
    SEL_PV  = 3'b001,
    SEL_SV  = 3'b010,
    SEL_TV  = 3'b011,
    SEL_QV  = 3'b100
  } lrts_sel_type;

endpackage

// ---- rtl/lrts_channel.sv ----
// Purpose: one relay limit channel with delay timer and restart latch
// Assumes: eval pulses with each new value, sec_tick once a second
// Notes:   signed 16-bit values, trip and hysteresis in the same scale
`timescale 1ns/10ps
`include "lrts_regs.svh"

module lrts_channel import lrts_pkg::*; (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               eval,
  input  wire logic               sec_tick,
  input  wire logic signed [15:0] value,
  input  wire logic signed [15:0] trip,
  input  wire logic signed [15:0] hyst,
  input  wire logic               enabled,
  input  wire logic               dir_max,
  input  wire logic               active,
  input  wire logic               inhibit,
  input  wire logic               fault_mode,
  input  wire logic               fault_any,
  input  wire logic [7:0]         delay_steps,
  input  wire logic               esc_press,
  output logic                    relay_on_ff,
  output logic                    tripped_ff
);

  logic              viol_ff;
  logic              pend_ff;
  logic [8:0]        secs_ff;
  wire logic         in_use  = enabled | fault_mode;
  wire logic         do_eval = eval | fault_mode;
  wire logic [7:0]   dly_cl  = (delay_steps > 8'(`LRTS_DELAY_STEPS_MAX)) ?
                               8'(`LRTS_DELAY_STEPS_MAX) : delay_steps;
  wire logic [8:0]   delay_s = 9'(dly_cl * 9'(`LRTS_DELAY_STEP_S));
  wire logic signed [16:0] band_lo = 17'(trip) - 17'(hyst);
  wire logic signed [16:0] band_hi = 17'(trip) + 17'(hyst);
  wire logic signed [16:0] val_x   = 17'(value);
  wire logic         over     = value > trip;
  wire logic         under    = value < trip;
  wire logic         safe_lim = dir_max ? (val_x < band_lo) : (val_x > band_hi);
  wire logic         viol_now = fault_mode ? fault_any : (dir_max ? over : under);
  wire logic         safe_now = fault_mode ? !fault_any : safe_lim;
  wire logic         pend_now = tripped_ff ? safe_now : viol_now;
  wire logic         delay_met = fault_mode | (delay_s == 9'h000) | (secs_ff > delay_s);
  wire logic         switch_ok = pend_ff & delay_met;
  wire logic         set_trip  = !tripped_ff & switch_ok;
  wire logic         clr_norm  = tripped_ff & switch_ok & !inhibit;
  wire logic         clr_latch = tripped_ff & inhibit & esc_press & !viol_ff;
  wire logic         nxt_tripped = !in_use ? 1'b0 : set_trip ? 1'b1 :
                                   (clr_norm | clr_latch) ? 1'b0 : tripped_ff;
  wire logic         nxt_relay_on = in_use & (active ? tripped_ff : !tripped_ff);

  // ---------------------------------------------------------------
  // timer and state
  // ---------------------------------------------------------------
  // short excursions reset the timer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      viol_ff <= 1'b0;
      pend_ff <= 1'b0;
      secs_ff <= 9'h000;
    end else if (nxt_tripped != tripped_ff) begin
      pend_ff <= 1'b0;
      secs_ff <= 9'h000;
    end else if (do_eval) begin
      viol_ff <= viol_now;
      pend_ff <= pend_now;
      if (!pend_now) secs_ff <= 9'h000;
    end else if (sec_tick && pend_ff && secs_ff != 9'h1ff) begin
      secs_ff <= secs_ff + 9'h001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tripped_ff  <= 1'b0;
      relay_on_ff <= 1'b0;
    end else begin
      tripped_ff  <= nxt_tripped;
      relay_on_ff <= nxt_relay_on;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_limit_trip;
    $rose(tripped_ff) && !fault_mode;
  endsequence

  a_trip_after_delay: assert property (
    s_limit_trip |-> $past(viol_ff) && ($past(delay_s) == 9'h000 ||
                     $past(secs_ff) > $past(delay_s)))
    else $error("relay tripped before delay elapsed");

  a_latch_hold_esc: assert property (
    inhibit && tripped_ff && in_use && !esc_press |=> tripped_ff)
    else $error("latched relay released without escape");

  a_release_refused: assert property (
    inhibit && tripped_ff && in_use && viol_ff |=> tripped_ff)
    else $error("latch released during violation");

  a_unused_relay_off: assert property (
    !in_use ##1 !in_use |-> !relay_on_ff)
    else $error("unassigned relay energized");

  a_relay_polarity: assert property (
    in_use && $stable(active) |=> relay_on_ff == ($past(active) ? $past(tripped_ff)
                                                 : !$past(tripped_ff)))
    else $error("relay polarity wrong");

endmodule // lrts_channel

// ---- rtl/lrts_top.sv ----
// Purpose: limit relay trip, status indicators and display status for a loop converter
// Assumes: loop receiver on ref_clk delivers decoded messages; esc_btn is a raw pin
// Notes:   AHB-Lite slave, word access only, reads take one wait state
`timescale 1ns/10ps
`include "lrts_regs.svh"

// Summary of operation
// - relay with neither an assigned variable nor fault mode stays de-energized always
// - each channel holds min/max direction and passive/active operation
// - max and active energizes relay as alarm above trip point
// - max and passive de-energizes relay above trip point, hysteresis band
// - min and active energizes relay as alarm below trip point
// - min and passive de-energizes relay below trip point, hysteresis band
// - trip only after violation lasts longer than response delay
// - untrip only after safe side with hysteresis lasts longer than delay
// - excursions no longer than the delay leave the relay unchanged
// - delay 0 to 250 s in 5 s steps, counted in seconds
// - restart inhibit latches the relay once switched
// - escape or restart releases latch, refused while violation remains
// - fault mode relay shows any device, communication or field device fault, latch refused while fault remains
// - factory reset restores all settings to defaults
// - green off unpowered, blinks in start-up, steady when running
// - red brief blink on single fault, regular blink on bad data
// - red steady on self-test fault and during reset
// - each yellow lit exactly while its relay is energized
// - displayed variables refresh on each value response
// - status and response code bytes shown as hex after a tag
// - loop state is locate, poll, burst or mixed
// - device fault, communication fault and field device failure flagged
// - communication fault when no valid message within 5 to 60 s timeout
module lrts_top import lrts_pkg::*; #(
  parameter int unsigned SEC_CYCLES = `LRTS_CLK_HZ * `LRTS_SEC_S
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        msg_valid,
  input  wire logic [7:0]  msg_cmd,
  input  wire logic [15:0] val_pv,
  input  wire logic [15:0] val_sv,
  input  wire logic [15:0] val_tv,
  input  wire logic [15:0] val_qv,
  input  wire logic [7:0]  dev_status,
  input  wire logic [7:0]  resp_code,
  input  wire logic        fault_msg,
  input  wire logic        field_dev_fail,
  input  wire logic        locating,
  input  wire logic        burst_seen,
  input  wire logic [7:0]  burst_cmd,
  input  wire logic        startup_busy,
  input  wire logic        self_test_fault,
  input  wire logic        esc_btn,
  output logic [3:0]       relay_out,
  output logic [3:0]       led_yellow,
  output logic             led_green,
  output logic             led_red
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  lrts_bus_type  state_ff;
  lrts_bus_type  nxt_state;
  logic [7:0]    addr_ff;
  logic [31:0]   hrdata_ff;
  logic [31:0]   cfg_ff [4];
  logic [31:0]   lim_ff [4];
  logic [3:0]    to_steps_ff;
  logic [15:0]   disp_pv_ff;
  logic [15:0]   disp_sv_ff;
  logic [15:0]   disp_tv_ff;
  logic [15:0]   disp_qv_ff;
  logic [7:0]    disp_stat_ff;
  logic [7:0]    disp_rc_ff;
  logic [24:0]   presc_ff;
  logic [5:0]    comm_secs_ff;
  logic          brief_ff;
  logic          esc_meta_ff;
  logic          esc_sync_ff;
  logic          esc_prev_ff;
  logic          green_ff;
  logic          red_ff;
  logic [3:0]    tripped;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? (8'h30 + 8'(n)) : (8'h37 + 8'(n));
  endfunction

  function automatic logic [15:0] sel_value(input logic [2:0] s);
    case (s)
      SEL_PV:  sel_value = val_pv;
      SEL_SV:  sel_value = val_sv;
      SEL_TV:  sel_value = val_tv;
      SEL_QV:  sel_value = val_qv;
      default: sel_value = 16'h0000;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // timebase and pin synchroniser
  // ---------------------------------------------------------------
  // one tick per second
  wire logic sec_tick  = presc_ff == 25'(SEC_CYCLES - 1);
  wire logic blink     = presc_ff < 25'(SEC_CYCLES / 2);
  wire logic esc_press = esc_sync_ff & !esc_prev_ff;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      presc_ff    <= 25'h0000000;
      esc_meta_ff <= 1'b0;
      esc_sync_ff <= 1'b0;
      esc_prev_ff <= 1'b0;
    end else begin
      presc_ff    <= sec_tick ? 25'h0000000 : presc_ff + 25'h0000001;
      esc_meta_ff <= esc_btn;
      esc_sync_ff <= esc_meta_ff;
      esc_prev_ff <= esc_sync_ff;
    end
  end

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  // reads wait one cycle so a write just before is always seen
  wire logic       take       = hsel & hready & htrans[1];
  wire logic       wr_now     = state_ff == BUS_WDATA;
  wire logic       ch_hit     = addr_ff[7:5] == `LRTS_CH_REGION;
  wire logic [1:0] ch_idx     = addr_ff[4:3];
  wire logic       freset     = wr_now && addr_ff == `LRTS_OFF_CTRL &&
                                hwdata[`LRTS_CTRL_FRESET];

  always_comb begin
    case (state_ff)
      BUS_RWAIT: nxt_state = BUS_RDATA;
      default:   nxt_state = !take ? BUS_IDLE : hwrite ? BUS_WDATA : BUS_RWAIT;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff  <= BUS_IDLE;
      addr_ff   <= 8'h00;
      hrdata_ff <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
      if (take) addr_ff <= {haddr[7:2], 2'b00};
      if (state_ff == BUS_RWAIT) hrdata_ff <= reg_read(addr_ff);
    end
  end

  assign hreadyout = state_ff != BUS_RWAIT;
  assign hrdata    = hrdata_ff;
  assign hresp     = 1'b0;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // direction and operation per channel
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      to_steps_ff <= `LRTS_TO_DEF_STEPS;
      for (int i = 0; i < 4; i++) begin
        cfg_ff[i] <= `LRTS_CFG_DEF;
        lim_ff[i] <= `LRTS_LIM_DEF;
      end
    end else if (freset) begin
      to_steps_ff <= `LRTS_TO_DEF_STEPS;
      for (int i = 0; i < 4; i++) begin
        cfg_ff[i] <= `LRTS_CFG_DEF;
        lim_ff[i] <= `LRTS_LIM_DEF;
      end
    end else if (wr_now) begin
      if (addr_ff == `LRTS_OFF_CTRL) to_steps_ff <= hwdata[`LRTS_CTRL_TO_LSB +: 4];
      if (ch_hit && !addr_ff[2]) cfg_ff[ch_idx] <= hwdata;
      if (ch_hit && addr_ff[2]) lim_ff[ch_idx] <= hwdata;
    end
  end

  // ---------------------------------------------------------------
  // display status
  // ---------------------------------------------------------------
  // refresh on value response
  // a value message starts one evaluation
  wire logic val_strobe = msg_valid && msg_cmd == `LRTS_CMD_VALUES;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      disp_pv_ff   <= 16'h0000;
      disp_sv_ff   <= 16'h0000;
      disp_tv_ff   <= 16'h0000;
      disp_qv_ff   <= 16'h0000;
      disp_stat_ff <= 8'h00;
      disp_rc_ff   <= 8'h00;
    end else if (val_strobe) begin
      disp_pv_ff   <= val_pv;
      disp_sv_ff   <= val_sv;
      disp_tv_ff   <= val_tv;
      disp_qv_ff   <= val_qv;
      disp_stat_ff <= dev_status;
      disp_rc_ff   <= resp_code;
    end
  end

  // status and code as hex text
  wire logic [31:0] disp_hex = {hex_char(disp_stat_ff[7:4]), hex_char(disp_stat_ff[3:0]),
                                hex_char(disp_rc_ff[7:4]), hex_char(disp_rc_ff[3:0])};

  wire lrts_loop_type loop_state = locating ? LOOP_LOCATE :
                                   !burst_seen ? LOOP_POLL :
                                   (burst_cmd == `LRTS_CMD_VALUES) ? LOOP_BURST : LOOP_MIXED;

  // ---------------------------------------------------------------
  // faults
  // ---------------------------------------------------------------
  // timeout counted in seconds
  wire logic [3:0] to_eff  = (to_steps_ff < 4'(`LRTS_TO_STEPS_MIN)) ? 4'(`LRTS_TO_STEPS_MIN) :
                             (to_steps_ff > 4'(`LRTS_TO_STEPS_MAX)) ? 4'(`LRTS_TO_STEPS_MAX) :
                             to_steps_ff;
  wire logic [5:0] to_secs = 6'(to_eff * 6'(`LRTS_TO_STEP_S));
  wire logic comm_fault    = comm_secs_ff >= to_secs;
  wire logic [2:0] faults  = {field_dev_fail, comm_fault, self_test_fault};
  wire logic fault_any     = |faults;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      comm_secs_ff <= 6'h00;
    end else if (msg_valid) begin
      comm_secs_ff <= 6'h00;
    end else if (sec_tick && comm_secs_ff != 6'h3f) begin
      comm_secs_ff <= comm_secs_ff + 6'h01;
    end
  end

  // ---------------------------------------------------------------
  // relay channels
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_ch
    // min passive via same band logic
    lrts_channel u_ch (
      .ref_clk     (ref_clk),
      .rst         (rst),
      .eval        (val_strobe),
      .sec_tick    (sec_tick),
      .value       (sel_value(cfg_ff[g][2:0])),
      .trip        (lim_ff[g][15:0]),
      .hyst        (lim_ff[g][31:16]),
      .enabled     (cfg_ff[g][2:0] != SEL_OFF),
      .dir_max     (cfg_ff[g][`LRTS_CFG_DIR_MAX]),
      .active      (cfg_ff[g][`LRTS_CFG_ACTIVE]),
      .inhibit     (cfg_ff[g][`LRTS_CFG_INHIBIT]),
      .fault_mode  (cfg_ff[g][`LRTS_CFG_FAULT]),
      .fault_any   (fault_any),
      .delay_steps (cfg_ff[g][`LRTS_CFG_DELAY_LSB +: 8]),
      .esc_press   (esc_press),
      .relay_on_ff (relay_out[g]),
      .tripped_ff  (tripped[g])
    );
  end

  // ---------------------------------------------------------------
  // indicators
  // ---------------------------------------------------------------
  // yellow mirrors relay
  assign led_yellow = relay_out;
  assign led_green  = green_ff;
  assign led_red    = red_ff;

  // red steady on self-test and reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      brief_ff <= 1'b0;
      green_ff <= 1'b0;
      red_ff   <= 1'b1;
    end else begin
      brief_ff <= fault_msg | (brief_ff & !sec_tick);
      green_ff <= startup_busy ? blink : 1'b1;
      red_ff   <= self_test_fault ? 1'b1 : (comm_fault | field_dev_fail) ? blink : brief_ff;
    end
  end

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  function automatic logic [31:0] reg_read(input logic [7:0] a);
    if (a[7:5] == `LRTS_CH_REGION) begin
      reg_read = a[2] ? lim_ff[a[4:3]] : cfg_ff[a[4:3]];
    end else begin
      case (a)
        `LRTS_OFF_CTRL:     reg_read = {24'h000000, to_steps_ff, 4'h0};
        `LRTS_OFF_STATUS:   reg_read = {16'h0000, tripped, relay_out, 2'b00, loop_state,
                                        1'b0, faults};
        `LRTS_OFF_DISP_TAG: reg_read = {16'h0000, `LRTS_RESP_TAG};
        `LRTS_OFF_DISP_HEX: reg_read = disp_hex;
        `LRTS_OFF_PV:       reg_read = {16'h0000, disp_pv_ff};
        `LRTS_OFF_SV:       reg_read = {16'h0000, disp_sv_ff};
        `LRTS_OFF_TV:       reg_read = {16'h0000, disp_tv_ff};
        `LRTS_OFF_QV:       reg_read = {16'h0000, disp_qv_ff};
        default:            reg_read = 32'h00000000;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_value_msg;
    msg_valid && msg_cmd == `LRTS_CMD_VALUES;
  endsequence

  a_display_refresh: assert property (
    s_value_msg |=> disp_pv_ff == $past(val_pv) && disp_rc_ff == $past(resp_code))
    else $error("display not refreshed on value message");

  a_red_selftest: assert property (
    self_test_fault |=> led_red)
    else $error("red not steady on self-test fault");

  a_green_running: assert property (
    !startup_busy |=> led_green)
    else $error("green not lit in normal operation");

  a_yellow_relay: assert property (
    led_yellow == relay_out)
    else $error("yellow differs from relay");

  a_comm_timeout: assert property (
    msg_valid |=> !comm_fault [*2])
    else $error("communication fault right after message");

  a_loop_locate: assert property (
    locating |-> loop_state == LOOP_LOCATE)
    else $error("loop state not locate");

  a_factory_default: assert property (
    freset |=> cfg_ff[0] == `LRTS_CFG_DEF && lim_ff[3] == `LRTS_LIM_DEF &&
               to_steps_ff == `LRTS_TO_DEF_STEPS)
    else $error("factory reset left settings");

  a_read_wait: assert property (
    take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

endmodule // lrts_top

// ---- dv/lrts_field_dev.sv ----
// Purpose: field device model, one value response per send pulse
// Assumes: send is a one-cycle pulse from the bench
// Notes:   idle lines toggle so stale data never looks valid
`timescale 1ns/10ps
module lrts_field_dev (
  input  wire logic        ref_clk,
  input  wire logic        send,
  input  wire logic [15:0] pv,
  output logic             msg_valid = 1'b0,
  output logic [7:0]       msg_cmd = 8'h00,
  output logic [15:0]      val_pv = 16'h0000
);
  always @(posedge ref_clk) begin
    msg_valid <= send;
    msg_cmd   <= send ? 8'h03 : ~msg_cmd;
    val_pv    <= send ? pv : ~val_pv;
  end
endmodule // lrts_field_dev

// ---- dv/tb.sv ----
// Purpose: self-checking bench of lrts_top
// Assumes: one second is 20 cycles here
// Notes:   relays compared 5 or more edges after each value
`timescale 1ns/10ps
module tb;
  logic        ref_clk, rst, hsel, hwrite, send, esc, hreadyout, hresp, msg_valid, green, red;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  msg_cmd, bcmd;
  logic        loc, bst, sb, stf;
  logic [15:0] pv, val;
  logic [3:0]  relay, yel;
  int          mismatches, comparisons, cyc;
  lrts_field_dev u_dev (.ref_clk, .send, .pv, .msg_valid, .msg_cmd, .val_pv(val));
  lrts_top #(.SEC_CYCLES(20)) u_dut (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .msg_valid,
    .msg_cmd, .val_pv(val), .val_sv(val), .val_tv(val), .val_qv(val),
    .dev_status(val[7:0]), .resp_code(val[15:8]), .fault_msg(1'b0), .field_dev_fail(1'b0),
    .locating(loc), .burst_seen(bst), .burst_cmd(bcmd), .startup_busy(sb),
    .self_test_fault(stf), .esc_btn(esc), .relay_out(relay), .led_yellow(yel),
    .led_green(green), .led_red(red));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) if (++cyc > 5000) begin
    mismatches++;
    results();
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task wt;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    wt();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wt();
    r = hrdata;
  endtask
  task value(input logic [15:0] v);
    pv <= v; send <= 1'b1;
    @(posedge ref_clk) send <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask
  task press;
    esc <= 1'b1;
    repeat (3) @(posedge ref_clk);
    esc <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
  task t_regs;
    repeat (3) @(posedge ref_clk);
    chk(green, 1'b1);
    bus(0, 8'h24, 0, rd); chk(rd, 32'h000a0050);
    bus(0, 8'h08, 0, rd); chk(rd, 32'h00005243);
    bus(0, 8'hfc, 0, rd); chk(rd, 32'h0);
    chk(hresp, 1'b0);
    value(16'd200); chk(relay, 4'h0);
    bus(0, 8'h10, 0, rd); chk(rd, 32'h000000c8);
    bus(0, 8'h0c, 0, rd); chk(rd, 32'h43383030);
    loc <= 1'b1; bus(0, 8'h04, 0, rd); chk(rd[5:4], 2'h0);
    loc <= 1'b0; bus(0, 8'h04, 0, rd); chk(rd[5:4], 2'h1);
    bst <= 1'b1; bus(0, 8'h04, 0, rd); chk(rd[5:4], 2'h2);
    bcmd <= 8'h01; bus(0, 8'h04, 0, rd); chk(rd[5:4], 2'h3);
  endtask
  task t_leds;
    int n, m;
    bus(1, 8'h28, 32'h00000050, rd);
    sb <= 1'b1; stf <= 1'b1;
    n = 0; m = 0;
    repeat (2) @(posedge ref_clk);
    repeat (20) begin
      @(posedge ref_clk);
      n += green;
      m += red;
    end
    chk(n, 10);
    chk(m, 20);
    chk(relay[1], 1'b1);
    bus(0, 8'h04, 0, rd); chk(rd[0], 1'b1);
    sb <= 1'b0; stf <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(green, 1'b1);
  endtask
  task t_modes;
    for (int m = 0; m < 4; m++) begin
      bus(1, 8'h20, {27'h0, m[1:0], 3'h1}, rd);
      value(m[0] ? 16'd50 : 16'd100); chk(relay[0], !m[1]);
      value(m[0] ? 16'd100 : 16'd50); chk(relay[0], m[1]);
      value(m[0] ? 16'd75 : 16'd85); chk(relay[0], m[1]);
      chk(relay, yel);
    end
  endtask
  task t_delay;
    value(16'd50);
    bus(1, 8'h20, 32'h00000119, rd);
    value(16'd100); chk(relay[0], 1'b0);
    repeat (60) @(posedge ref_clk);
    value(16'd50); repeat (100) @(posedge ref_clk); chk(relay[0], 1'b0);
    value(16'd100); repeat (140) @(posedge ref_clk);
    value(16'd100); chk(relay[0], 1'b1);
  endtask
  task t_latch;
    bus(1, 8'h20, 32'h00000039, rd);
    value(16'd50); chk(relay[0], 1'b1);
    value(16'd100); press(); chk(relay[0], 1'b1);
    value(16'd50); press(); chk(relay[0], 1'b0);
    bus(1, 8'h00, 32'h1, rd);
    bus(0, 8'h20, 0, rd); chk(rd, 32'h0);
  endtask
  task results;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    {hsel, hwrite, send, esc, rst} = 5'h01; htrans = 2'h0; haddr = 32'h0; hwdata = 32'h0;
    pv = 16'h0; bcmd = 8'h03; {loc, bst, sb, stf} = 4'h0;
    repeat (10) @(posedge ref_clk);
    chk(red, 1'b1);
    rst <= 1'b0;
    t_regs(); t_modes(); t_delay(); t_latch(); t_leds();
    results();
  end
endmodule // tb
